// File: design/cp0dr_regs.sv
/*
 * Diagnostic coprocessor registers and hardware reset initialisation:
 * data-cache tag high word, outer-cache data high word, error restart
 * PC, debug scratch word, reset-forced control bits, hidden TLB entry
 * initialisation bits, bus abort and reset fetch address.
 * Assumes the surrounding coprocessor owns the full status, config and
 * debug registers and loads changes through the control update port.
 */
// Summary of operation
// RULE1: Tag high word bits 31:12 hold the virtual tag for fast lookup.
// RULE2: Index load tag loads bit 11 from virtual address bit 11.
// RULE3: Bits 7:0 hold the space identifier, bit 8 the global flag.
// RULE4: Outer data high word carries upper 32 bits of index data ops.
// RULE5: Error restart PC captured on cache error, reset, error-level trap.
// RULE6: Debug scratch word is read/write with no hardware effect.
// RULE7: One reset input serves power-up and soft reset alike.
// RULE8: Reset loads random index with maximum and wired limit with zero.
// RULE9: Reset sets vector select, error level; clears shutdown, NMI, power.
// RULE10: Reset clears device map enable and watchpoint access enables.
// RULE11: Config fields from static inputs take those inputs at reset.
// RULE12: Reset makes kseg0, and in fixed mapping user/kseg2-3, uncached.
// RULE13: Reset clears debug mode unless debug boot option is selected.
// RULE14: Reset clears normal-map, bus error pending, inhibit, single step.
// RULE15: Hidden per-entry TLB bit set by reset blocks matches until written.
// RULE16: The hidden TLB bit is not reachable by any software register.
// RULE17: Reset aborts pending bus transactions and resets bus machines.
// RULE18: System changes static configuration inputs only during reset.
// RULE19: Fetch starts at 0xBFC00000, physical 0x1FC00000, unless debug boot.
// RULE20: Reset touches only listed state; diagnostic words left as found.
// RULE21: Reset does not alter cache tag or data arrays.
// RULE22: Tag high word bits 10 and 9 read zero, writes ignored.
`timescale 1ns/100ps
module cp0dr_regs #(
  parameter int unsigned TLB_ENTRIES = 32,
  parameter bit TLB_PRESENT = 1'b1,
  parameter bit FIXED_MAP = 1'b0,
  parameter int unsigned CFG_W = 16,
  parameter logic [31:0] DEBUG_BOOT_VA = 32'h0000_0000
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Coprocessor move port.
  input wire cp0dr_pkg::cp0dr_move_t move_i,
  output logic [31:0] move_rdata_o,
  output logic move_rvalid_o,
  // Cache index operations.
  input wire cp0dr_pkg::cp0dr_cacheop_t cacheop_i,
  output logic [31:0] outer_data_o,
  output logic outer_data_valid_o,
  output logic [cp0dr_pkg::WORD_SEL_W-1:0] outer_word_sel_o,
  // Exceptions that enter error level.
  input wire logic err_exc_i,
  input wire logic [31:0] err_exc_pc_i,
  input wire logic [31:0] reset_pc_i,
  // Control bits held for the rest of the coprocessor.
  input wire logic ctl_load_i,
  input wire cp0dr_pkg::cp0dr_ctl_t ctl_new_i,
  output cp0dr_pkg::cp0dr_ctl_t ctl_o,
  // TLB replacement and entry state.
  input wire logic wired_load_i,
  input wire logic [$clog2(TLB_ENTRIES)-1:0] wired_new_i,
  input wire logic tlb_write_i,
  input wire logic [$clog2(TLB_ENTRIES)-1:0] tlb_write_idx_i,
  output logic [$clog2(TLB_ENTRIES)-1:0] random_index_o,
  output logic [$clog2(TLB_ENTRIES)-1:0] wired_limit_o,
  output logic [TLB_ENTRIES-1:0] tlb_match_en_o,
  // Static configuration and boot straps.
  input wire logic [CFG_W-1:0] cfg_static_i,
  input wire logic debug_boot_option_i,
  output logic [CFG_W-1:0] cfg_static_o,
  // Bus interface and fetch start.
  output logic bus_abort_o,
  output logic fetch_start_o,
  output logic [31:0] fetch_va_o
);
  import cp0dr_pkg::*;

  localparam int unsigned IDX_W = $clog2(TLB_ENTRIES);
  localparam logic [IDX_W-1:0] IDX_MAX = IDX_W'(TLB_ENTRIES - 1);
  localparam logic [IDX_W-1:0] IDX_ZERO = IDX_W'(0);
  localparam logic [IDX_W-1:0] RANDOM_RESET = TLB_PRESENT ? IDX_MAX : IDX_ZERO;
  localparam logic [2:0] FM_CCA_RESET = FIXED_MAP ? CCA_UNCACHED : CCA_CLEAR;
  localparam logic [CFG_W-1:0] CFG_CLEAR = CFG_W'(0);

  localparam cp0dr_ctl_t CTL_RESET = '{
    bootstrap_vector_sel: 1'b1,
    error_level_flag: 1'b1,
    tlb_shutdown_flag: 1'b0,
    nmi_flag: 1'b0,
    reduced_power_flag: 1'b0,
    device_map_en: 1'b0,
    watch_access_enables: 3'h0,
    kseg_zero_cacheability: CCA_UNCACHED,
    user_seg_cacheability: FM_CCA_RESET,
    kseg_high_cacheability: FM_CCA_RESET,
    debug_mode_flag: 1'b0,
    loadstore_normal_map: 1'b0,
    instr_bus_err_pending: 1'b0,
    data_bus_err_pending: 1'b0,
    imprecise_exc_inhibit: 1'b0,
    single_step_enable: 1'b0
  };

  typedef struct packed {
    cp0dr_ctl_t ctl;
    logic [IDX_W-1:0] random_index;
    logic [IDX_W-1:0] wired_limit;
    logic [TLB_ENTRIES-1:0] match_en;
    logic [CFG_W-1:0] cfg;
    logic rst_pend;
    logic bus_abort;
    logic fetch_start;
    logic [31:0] fetch_va;
    logic move_rvalid;
    logic outer_valid;
    logic [WORD_SEL_W-1:0] word_sel;
  } cp0dr_state_t;

  cp0dr_state_t state;
  cp0dr_state_t next_state;

  logic [TLB_ENTRIES-1:0] next_match_en;
  logic mv_hit;
  logic [1:0] mv_idx;
  logic st_we;
  logic [1:0] st_widx;
  logic [31:0] st_wdata;
  logic [31:0] st_wmask;
  logic st_re;
  logic st_rzero;
  logic [1:0] st_ridx;

  // Register decode of a coprocessor move by number and select.
  always_comb begin
    mv_hit = 1'b1;
    mv_idx = IDX_DBG_SAVE;
    if (move_i.reg_num == REG_TAG_HI_NUM && move_i.sel == REG_TAG_HI_SEL) begin
      mv_idx = IDX_TAG_HI;
    end else if (move_i.reg_num == REG_OUTER_HI_NUM &&
                 move_i.sel == REG_OUTER_HI_SEL) begin
      mv_idx = IDX_OUTER_HI;
    end else if (move_i.reg_num == REG_ERR_PC_NUM &&
                 move_i.sel == REG_ERR_PC_SEL) begin
      mv_idx = IDX_ERR_PC;
    end else if (move_i.reg_num == REG_DBG_SAVE_NUM &&
                 move_i.sel == REG_DBG_SAVE_SEL) begin
      mv_idx = IDX_DBG_SAVE;
    end else begin
      mv_hit = 1'b0;
    end
  end

  // Write arbitration into the diagnostic store. A software write that
  // collides with a hardware update is dropped, since the hardware event
  // reflects machine state that software cannot replay.
  always_comb begin
    st_we = 1'b0;
    st_widx = IDX_ERR_PC;
    st_wdata = ZERO_WORD;
    st_wmask = FULL_MASK;
    if (state.rst_pend) begin
      // RULE5: capture on reset
      st_we = 1'b1;
      st_wdata = reset_pc_i;
    end else if (err_exc_i) begin
      // RULE5: capture on error trap
      st_we = 1'b1;
      st_wdata = err_exc_pc_i;
    end else if (cacheop_i.ld_tag) begin
      st_we = 1'b1;
      st_widx = IDX_TAG_HI;
      st_wmask = TAG_WR_MASK;
      // RULE1: virtual tag field
      st_wdata[TAG_VIRTUAL_LINE_TAG_MSB:TAG_VIRTUAL_LINE_TAG_LSB] =
        cacheop_i.vaddr[TAG_VIRTUAL_LINE_TAG_MSB:TAG_VIRTUAL_LINE_TAG_LSB];
      // RULE2: address bit 11
      st_wdata[TAG_VA11_BIT] = cacheop_i.vaddr[TAG_VA11_BIT];
      // RULE3: identifier and global
      st_wdata[ADDRESS_SPACE_IDENT_W] = cacheop_i.global_flag;
      st_wdata[ADDRESS_SPACE_IDENT_W-1:0] = cacheop_i.address_space_ident;
    end else if (cacheop_i.ld_data) begin
      // RULE4: upper data word
      st_we = 1'b1;
      st_widx = IDX_OUTER_HI;
      st_wdata = cacheop_i.data_hi;
    end else if (move_i.wr && mv_hit) begin
      // RULE6: plain scratch write
      st_we = 1'b1;
      st_widx = mv_idx;
      st_wdata = move_i.wdata;
      // RULE22: bits 10:9 masked out of the write
      st_wmask = (mv_idx == IDX_TAG_HI) ? TAG_WR_MASK : FULL_MASK;
    end
  end

  // Read arbitration: a store-data cache operation outranks a move read.
  always_comb begin
    st_re = 1'b0;
    st_rzero = 1'b0;
    st_ridx = IDX_OUTER_HI;
    if (cacheop_i.st_data) begin
      // RULE4: upper data word
      st_re = 1'b1;
    end else if (move_i.rd) begin
      st_re = 1'b1;
      st_rzero = !mv_hit;
      st_ridx = mv_idx;
    end
  end

  // RULE15: per-entry hidden bit
  generate
    for (genvar e = 0; e < TLB_ENTRIES; e++) begin : g_tlb_init
      assign next_match_en[e] = state.match_en[e] |
        (tlb_write_i && tlb_write_idx_i == IDX_W'(e));
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.match_en = next_match_en;
    next_state.move_rvalid = move_i.rd && !cacheop_i.st_data;
    next_state.outer_valid = cacheop_i.st_data;
    next_state.fetch_start = 1'b0;
    if (cacheop_i.ld_data || cacheop_i.st_data) begin
      // RULE4: word of the line
      next_state.word_sel = cacheop_i.vaddr[WORD_SEL_LSB +: WORD_SEL_W];
    end
    if (ctl_load_i) begin
      next_state.ctl = ctl_new_i;
    end
    if (wired_load_i) begin
      next_state.wired_limit = wired_new_i;
    end
    if (err_exc_i) begin
      next_state.ctl.error_level_flag = 1'b1;
    end
    if (state.rst_pend) begin
      // First edge after release: straps and static inputs are sampled.
      next_state.rst_pend = 1'b0;
      // RULE17: abort ends after release
      next_state.bus_abort = 1'b0;
      // RULE11: static config capture
      next_state.cfg = cfg_static_i;
      // RULE13: debug boot strap
      next_state.ctl.debug_mode_flag = debug_boot_option_i;
      // RULE19: reset fetch address
      next_state.fetch_va = debug_boot_option_i ? DEBUG_BOOT_VA
                                                : RESET_FETCH_VA;
      next_state.fetch_start = 1'b1;
    end
  end

  // RULE7: single reset input
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // RULE9: status bits forced
      // RULE10: map and watch cleared
      // RULE12: uncached segments
      // RULE14: debug bits cleared
      state.ctl <= CTL_RESET;
      // RULE8: random max, wired zero
      state.random_index <= RANDOM_RESET;
      state.wired_limit <= IDX_ZERO;
      // RULE15: all entries blocked
      state.match_en <= '0;
      state.cfg <= CFG_CLEAR;
      state.rst_pend <= 1'b1;
      // RULE17: bus held aborted
      state.bus_abort <= 1'b1;
      state.fetch_start <= 1'b0;
      state.fetch_va <= RESET_FETCH_VA;
      state.move_rvalid <= 1'b0;
      state.outer_valid <= 1'b0;
      state.word_sel <= '0;
    end else begin
      state <= next_state;
    end
  end

  // RULE20: diagnostic words not reset
  // RULE21: cache arrays untouched
  cp0dr_diag_store u_store (
    .sys_clk_i(sys_clk_i),
    .we_i(st_we),
    .widx_i(st_widx),
    .wdata_i(st_wdata),
    .wmask_i(st_wmask),
    .re_i(st_re),
    .rzero_i(st_rzero),
    .ridx_i(st_ridx),
    .rdata_o(move_rdata_o)
  );

  // The store's read register serves both answer paths.
  assign outer_data_o = move_rdata_o;
  assign move_rvalid_o = state.move_rvalid;
  assign outer_data_valid_o = state.outer_valid;
  assign outer_word_sel_o = state.word_sel;
  assign ctl_o = state.ctl;
  assign random_index_o = state.random_index;
  assign wired_limit_o = state.wired_limit;
  // RULE16: hidden bit only drives match enables
  assign tlb_match_en_o = state.match_en;
  assign cfg_static_o = state.cfg;
  assign bus_abort_o = state.bus_abort;
  assign fetch_start_o = state.fetch_start;
  assign fetch_va_o = state.fetch_va;

endmodule : cp0dr_regs

// File: design/cp0dr_pkg.sv
/*
 * Shared constants and carrier types for the coprocessor-0 diagnostic
 * register block and its reset initialisation logic.
 * Assumes a single core clock domain and that every user imports it.
 */
package cp0dr_pkg;

  // Coprocessor register number and select of each diagnostic register.
  localparam logic [4:0] REG_TAG_HI_NUM = 5'h1d;
  localparam logic [2:0] REG_TAG_HI_SEL = 3'h2;
  localparam logic [4:0] REG_OUTER_HI_NUM = 5'h1d;
  localparam logic [2:0] REG_OUTER_HI_SEL = 3'h5;
  localparam logic [4:0] REG_ERR_PC_NUM = 5'h1e;
  localparam logic [2:0] REG_ERR_PC_SEL = 3'h0;
  localparam logic [4:0] REG_DBG_SAVE_NUM = 5'h1f;
  localparam logic [2:0] REG_DBG_SAVE_SEL = 3'h0;

  // Word index of each register inside the diagnostic store.
  localparam logic [1:0] IDX_TAG_HI = 2'h0;
  localparam logic [1:0] IDX_OUTER_HI = 2'h1;
  localparam logic [1:0] IDX_ERR_PC = 2'h2;
  localparam logic [1:0] IDX_DBG_SAVE = 2'h3;
  localparam int unsigned STORE_WORDS = 4;

  // Field layout of dcache_virtual_tag_high.
  localparam int unsigned TAG_VIRTUAL_LINE_TAG_MSB = 31;
  localparam int unsigned TAG_VIRTUAL_LINE_TAG_LSB = 12;
  localparam int unsigned TAG_VA11_BIT = 11;
  localparam int unsigned ADDRESS_SPACE_IDENT_W = 8;
  localparam logic [1:0] TAG_ZERO_FIELD = 2'h0;
  localparam logic [31:0] TAG_WR_MASK = 32'hffff_f9ff;
  localparam logic [31:0] FULL_MASK = 32'hffff_ffff;

  // Cache line word select: 32-byte line of 32-bit words.
  localparam int unsigned WORD_SEL_LSB = 2;
  localparam int unsigned WORD_SEL_W = 3;

  // Reset values.
  localparam logic [2:0] CCA_UNCACHED = 3'h2;
  localparam logic [2:0] CCA_CLEAR = 3'h0;
  localparam logic [31:0] RESET_FETCH_VA = 32'hbfc0_0000;
  localparam logic [31:0] RESET_FETCH_PA = 32'h1fc0_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Reset-forced control bits owned by the status, config, map and
  // debug registers of the coprocessor.
  typedef struct packed {
    logic bootstrap_vector_sel;
    logic error_level_flag;
    logic tlb_shutdown_flag;
    logic nmi_flag;
    logic reduced_power_flag;
    logic device_map_en;
    logic [2:0] watch_access_enables;
    logic [2:0] kseg_zero_cacheability;
    logic [2:0] user_seg_cacheability;
    logic [2:0] kseg_high_cacheability;
    logic debug_mode_flag;
    logic loadstore_normal_map;
    logic instr_bus_err_pending;
    logic data_bus_err_pending;
    logic imprecise_exc_inhibit;
    logic single_step_enable;
  } cp0dr_ctl_t;

  // Coprocessor move request.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] reg_num;
    logic [2:0] sel;
    logic [31:0] wdata;
  } cp0dr_move_t;

  // Data-cache and outer-cache index operation request.
  typedef struct packed {
    logic ld_tag;
    logic ld_data;
    logic st_data;
    logic [31:0] vaddr;
    logic [ADDRESS_SPACE_IDENT_W-1:0] address_space_ident;
    logic global_flag;
    logic [31:0] data_hi;
  } cp0dr_cacheop_t;

endpackage : cp0dr_pkg

// File: design/cp0dr_diag_store.sv
/*
 * Four-word store for the diagnostic registers, masked write port and
 * one read port whose data come out of a register.
 * Assumes the caller arbitrates writes; contents are never reset.
 */
`timescale 1ns/100ps
module cp0dr_diag_store (
  // Clock.
  input wire logic sys_clk_i,
  // Write port.
  input wire logic we_i,
  input wire logic [1:0] widx_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] wmask_i,
  // Read port.
  input wire logic re_i,
  input wire logic rzero_i,
  input wire logic [1:0] ridx_i,
  output logic [31:0] rdata_o
);
  import cp0dr_pkg::*;

  typedef struct packed {
    logic [STORE_WORDS-1:0][31:0] word;
    logic [31:0] rdata;
  } cp0dr_store_t;

  cp0dr_store_t state;
  cp0dr_store_t next_state;

  always_comb begin
    next_state = state;
    if (we_i) begin
      next_state.word[widx_i] = (state.word[widx_i] & ~wmask_i) |
                                (wdata_i & wmask_i);
    end
    // An unmapped read answers zero rather than stale data.
    if (re_i) begin
      next_state.rdata = rzero_i ? ZERO_WORD : state.word[ridx_i];
      // RULE22: tag gap reads zero
      // The gap bits are never written, so they are masked on the way out.
      if (!rzero_i && ridx_i == IDX_TAG_HI) begin
        next_state.rdata = state.word[ridx_i] & TAG_WR_MASK;
      end
    end
  end

  // No reset: the diagnostic words stay as found until the write port writes them.
  always_ff @(posedge sys_clk_i) begin
    state <= next_state;
  end

  assign rdata_o = state.rdata;

endmodule : cp0dr_diag_store

// File: verification/cp0dr_regs_sva.sv
/* Concurrent checks on the ports of cp0dr_regs, bound to each instance.
   Assumes one core clock and the active-low asynchronous reset. */
`timescale 1ns/100ps
module cp0dr_regs_sva #(
  parameter int unsigned TLB_ENTRIES = 32,
  parameter int unsigned CFG_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire cp0dr_pkg::cp0dr_move_t move_i,
  input wire logic [31:0] move_rdata_o,
  input wire logic move_rvalid_o,
  input wire cp0dr_pkg::cp0dr_cacheop_t cacheop_i,
  input wire logic outer_data_valid_o,
  input wire logic [cp0dr_pkg::WORD_SEL_W-1:0] outer_word_sel_o,
  input wire logic err_exc_i,
  input wire cp0dr_pkg::cp0dr_ctl_t ctl_o,
  input wire logic wired_load_i,
  input wire logic [$clog2(TLB_ENTRIES)-1:0] wired_new_i,
  input wire logic tlb_write_i,
  input wire logic [$clog2(TLB_ENTRIES)-1:0] tlb_write_idx_i,
  input wire logic [$clog2(TLB_ENTRIES)-1:0] wired_limit_o,
  input wire logic [TLB_ENTRIES-1:0] tlb_match_en_o,
  input wire logic [CFG_W-1:0] cfg_static_o,
  input wire logic bus_abort_o,
  input wire logic fetch_start_o,
  input wire logic [31:0] fetch_va_o
);
  import cp0dr_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_read_answer: assert property (
    move_i.rd && !cacheop_i.st_data |=> move_rvalid_o)
    else $error("read got no answer");
  a_tag_gap: assert property (
    move_i.rd && !cacheop_i.st_data && move_i.reg_num == REG_TAG_HI_NUM
    && move_i.sel == REG_TAG_HI_SEL |=> move_rdata_o[10:9] == TAG_ZERO_FIELD)
    else $error("tag gap bits not zero");
  a_store_word: assert property (
    cacheop_i.st_data |=> outer_data_valid_o
    && outer_word_sel_o == $past(cacheop_i.vaddr[4:2]))
    else $error("store word select wrong");
  a_error_level: assert property (
    err_exc_i |=> ctl_o.error_level_flag) else $error("error level not set");
  a_tlb_enable: assert property (
    tlb_write_i |=> tlb_match_en_o[$past(tlb_write_idx_i)])
    else $error("entry not enabled");
  a_match_kept: assert property (
    ($past(tlb_match_en_o) & ~tlb_match_en_o) == '0)
    else $error("entry enable lost");
  a_wired_load: assert property (
    wired_load_i |=> wired_limit_o == $past(wired_new_i))
    else $error("wired limit not loaded");
  a_abort_fetch: assert property (
    $fell(bus_abort_o) |-> fetch_start_o ##1 !fetch_start_o)
    else $error("fetch start not one pulse");
  a_fetch_addr: assert property (
    fetch_start_o && !ctl_o.debug_mode_flag |-> fetch_va_o == RESET_FETCH_VA)
    else $error("wrong reset fetch address");
  a_cfg_held: assert property (
    !fetch_start_o |-> $stable(cfg_static_o)) else $error("config moved");
  c_store: cover property (cacheop_i.st_data ##1 outer_data_valid_o);
  c_error: cover property (err_exc_i ##1 ctl_o.error_level_flag);
  c_fetch: cover property ($fell(bus_abort_o));
endmodule : cp0dr_regs_sva

bind cp0dr_regs cp0dr_regs_sva #(.TLB_ENTRIES(TLB_ENTRIES), .CFG_W(CFG_W))
  u_sva (.sys_clk_i, .arst_n_i, .move_i, .move_rdata_o, .move_rvalid_o,
  .cacheop_i, .outer_data_valid_o, .outer_word_sel_o, .err_exc_i, .ctl_o,
  .wired_load_i, .wired_new_i, .tlb_write_i, .tlb_write_idx_i,
  .wired_limit_o, .tlb_match_en_o, .cfg_static_o, .bus_abort_o,
  .fetch_start_o, .fetch_va_o);

// File: verification/cp0dr_regs_tb.sv
/* Self-checking bench for cp0dr_regs: reset state, moves, cache index
   ops, error entry, TLB enables and a second reset with debug boot.
   Assumes the package and design are compiled before it. */
`timescale 1ns/100ps
module cp0dr_regs_tb;
  import cp0dr_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  cp0dr_move_t mv = '0;
  cp0dr_cacheop_t co = '0;
  cp0dr_ctl_t ctl, rexp;
  cp0dr_ctl_t cn = '0;
  logic [31:0] rdat, odat, fva, men, d;
  logic [31:0] epc = 32'h0;
  logic [31:0] rpc = 32'h0000_1234;
  logic rvld, ovld, ab, fs;
  logic ee = 1'b0, cl = 1'b0, wl = 1'b0, tw = 1'b0, boot = 1'b0;
  logic [2:0] wsel;
  logic [4:0] wn = 5'h0, twi = 5'h0, rnd, wrd;
  logic [15:0] cfg = 16'h0, cfgo;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  cp0dr_regs DUT (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .move_i(mv),
    .move_rdata_o(rdat), .move_rvalid_o(rvld), .cacheop_i(co),
    .outer_data_o(odat), .outer_data_valid_o(ovld), .outer_word_sel_o(wsel),
    .err_exc_i(ee), .err_exc_pc_i(epc), .reset_pc_i(rpc),
    .ctl_load_i(cl), .ctl_new_i(cn), .ctl_o(ctl), .wired_load_i(wl),
    .wired_new_i(wn), .tlb_write_i(tw), .tlb_write_idx_i(twi),
    .random_index_o(rnd), .wired_limit_o(wrd), .tlb_match_en_o(men),
    .cfg_static_i(cfg), .debug_boot_option_i(boot), .cfg_static_o(cfgo),
    .bus_abort_o(ab), .fetch_start_o(fs), .fetch_va_o(fva)
  );

  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // The whole run needs under a hundred cycles; this cuts a hang short.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      $display("ERROR %0t run timed out", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [4:0] n, input logic [2:0] s);
    @(negedge sys_clk_i);
    mv = '{1'b1, 1'b0, n, s, 32'h0};
    @(negedge sys_clk_i);
    mv = '0;
    chk({31'h0, rvld}, 32'h1);
    d = rdat;
  endtask : rd

  // The read follows the write with no gap, the tightest legal order.
  task automatic wr_rd(input logic [4:0] n, input logic [2:0] s,
                       input logic [31:0] w, input logic [31:0] e);
    @(negedge sys_clk_i);
    mv = '{1'b0, 1'b1, n, s, w};
    rd(n, s);
    chk(d, e);
  endtask : wr_rd

  task automatic cop(input logic [2:0] op, input logic [31:0] va,
                     input logic [31:0] dh);
    @(negedge sys_clk_i);
    co = '{op[2], op[1], op[0], va, 8'h3c, 1'b1, dh};
    @(negedge sys_clk_i);
    co = '0;
  endtask : cop

  task automatic t_reset(input logic b, input logic [15:0] c);
    @(negedge sys_clk_i);
    arst_n_i = 1'b0;
    boot = b;
    cfg = c;
    repeat (16) @(negedge sys_clk_i);
    rexp = '0;
    rexp.bootstrap_vector_sel = 1'b1;
    rexp.error_level_flag = 1'b1;
    rexp.kseg_zero_cacheability = CCA_UNCACHED;
    chk({8'h0, ctl}, {8'h0, rexp});
    chk({22'h0, rnd, wrd}, {22'h0, 5'h1f, 5'h0});
    chk(men, 32'h0);
    chk({30'h0, ab, fs}, 32'h2);
    chk(fva, RESET_FETCH_VA);
    arst_n_i = 1'b1;
    @(negedge sys_clk_i);
    chk({30'h0, ab, fs}, 32'h1);
    chk({15'h0, ctl.debug_mode_flag, cfgo}, {15'h0, b, c});
    chk(fva, b ? 32'h0 : RESET_FETCH_VA);
    rd(5'h1e, 3'h0);
    chk(d, rpc);
  endtask : t_reset

  task automatic t_moves();
    wr_rd(5'h1f, 3'h0, 32'hdead_beef, 32'hdead_beef);
    wr_rd(5'h1d, 3'h2, FULL_MASK, 32'hffff_f9ff);
    wr_rd(5'h1d, 3'h5, 32'h5a5a_a5a5, 32'h5a5a_a5a5);
    wr_rd(5'h1e, 3'h0, 32'h1357_9bdf, 32'h1357_9bdf);
    wr_rd(5'h1f, 3'h1, FULL_MASK, 32'h0);
    rd(5'h1f, 3'h0);
    chk(d, 32'hdead_beef);
  endtask : t_moves

  task automatic t_cache();
    cop(3'h4, 32'h1234_5a80, 32'h0);
    rd(5'h1d, 3'h2);
    chk(d, 32'h1234_593c);
    cop(3'h2, 32'h0000_000c, 32'hc001_d00d);
    rd(5'h1d, 3'h5);
    chk(d, 32'hc001_d00d);
    cop(3'h1, 32'h0000_0014, 32'h0);
    chk({28'h0, ovld, wsel}, 32'hd);
    chk(odat, 32'hc001_d00d);
  endtask : t_cache

  task automatic t_error();
    @(negedge sys_clk_i);
    cl = 1'b1;
    @(negedge sys_clk_i);
    cl = 1'b0;
    ee = 1'b1;
    epc = 32'h8000_0180;
    chk({31'h0, ctl.error_level_flag}, 32'h0);
    @(negedge sys_clk_i);
    ee = 1'b0;
    chk({31'h0, ctl.error_level_flag}, 32'h1);
    rd(5'h1e, 3'h0);
    chk(d, 32'h8000_0180);
  endtask : t_error

  task automatic t_tlb();
    @(negedge sys_clk_i);
    tw = 1'b1;
    wl = 1'b1;
    wn = 5'h07;
    @(negedge sys_clk_i);
    twi = 5'h1f;
    wl = 1'b0;
    @(negedge sys_clk_i);
    tw = 1'b0;
    chk(men, 32'h8000_0001);
    chk({22'h0, rnd, wrd}, {22'h0, 5'h1f, 5'h07});
  endtask : t_tlb

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  initial begin
    t_reset(1'b0, 16'h00a5);
    t_moves();
    t_cache();
    t_error();
    t_tlb();
    t_reset(1'b1, 16'h5a00);
    rd(5'h1f, 3'h0);
    chk(d, 32'hdead_beef);
    end_of_test();
  end
endmodule : cp0dr_regs_tb
